// ==== design/ioad_pkg.sv ====
// Purpose : shared constants and types for the port address decoder pair
// Assumes : 8-bit data bus, 16-bit byte address, one 20 MHz clock
// Notes   : both ends and the bench reach these as ioad_pkg::name
`default_nettype none

package ioad_pkg;
    // =========================================================
    // bus geometry
    localparam int ADDR_W       = 16;
    localparam int DATA_W       = 8;
    localparam int MEM_BYTES    = 65536;   // whole byte space
    localparam int MAPPED_BYTES = 32768;   // memory left when mapped
    localparam int IO_FLAG_BIT  = 15;      // high bit marks I/O space
    // =========================================================
    // port and enable fields
    localparam int PORT_SEL_W   = 2;       // port inside one device
    localparam int ENABLE_LSB   = 2;       // first enable bit
    localparam int ISO_DEVS     = 6;       // linear, isolated space
    localparam int MM_DEVS      = 13;      // linear, mapped space
    localparam int ISO_FIELD_W  = ISO_DEVS;
    localparam int MM_FIELD_W   = MM_DEVS;
    // =========================================================
    // cycle timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int STROBE_CYCLES = 2;      // T3 length in clocks
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // addressing style of the system
    typedef enum logic { IOAD_ISOLATED, IOAD_MAPPED } ioad_map_t;
    // how a device enable is formed
    typedef enum logic { IOAD_EXCLUSIVE, IOAD_LINEAR } ioad_sel_t;
    // transfers the processor end can run
    typedef enum logic [2:0] {
        IOAD_MEM_READ, IOAD_MEM_WRITE, IOAD_PORT_IN, IOAD_PORT_OUT,
        IOAD_PAIR_READ, IOAD_PAIR_WRITE
    } ioad_op_t;
endpackage : ioad_pkg

`default_nettype wire

// ==== design/ioad_bus_if.sv ====
// Purpose : processor address, data and control bus between both ends
// Assumes : both ends on one clock; no clocking block
// Notes   : strobes are active-high levels held for the whole of T3
`default_nettype none

interface ioad_bus_if;
    // =========================================================
    // address and data
    logic [ioad_pkg::ADDR_W-1:0] addr;
    logic [ioad_pkg::DATA_W-1:0] wdata;
    logic [ioad_pkg::DATA_W-1:0] rdata;
    // =========================================================
    // control strobes
    logic                        memory_read_strobe;
    logic                        memory_write_strobe;
    logic                        io_read_strobe;
    logic                        io_write_strobe;

    // processor end drives address, write data and strobes
    modport cpu (
        output addr, wdata, memory_read_strobe, memory_write_strobe,
               io_read_strobe, io_write_strobe,
        input  rdata
    );
    // decoder end answers with read data
    modport dec (
        input  addr, wdata, memory_read_strobe, memory_write_strobe,
               io_read_strobe, io_write_strobe,
        output rdata
    );
endinterface : ioad_bus_if

`default_nettype wire

// ==== design/ioad_cpu_end.sv ====
// Purpose : processor end; runs memory, port and pair bus cycles
// Assumes : one request at a time, taken only while idle
// Notes   : T1 address, T2 hold, T3 strobe, then one gap cycle
`default_nettype none

module ioad_cpu_end (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst_n,
    // request from the user side
    input  wire logic               req,
    input  wire ioad_pkg::ioad_op_t op,
    input  wire logic [7:0]         byte2,
    input  wire logic [7:0]         byte3,
    input  wire logic [15:0]        write_data,
    // answer to the user side
    output logic                    busy,
    output logic                    done,
    output logic [15:0]             read_data,
    // processor bus
    ioad_bus_if.cpu                 bus
);
    // =========================================================
    // bus cycle sequencer
    typedef enum logic [2:0] {
        ST_IDLE, ST_T1, ST_T2, ST_T3, ST_GAP
    } ioad_cyc_t;

    ioad_cyc_t          state, next_state;
    ioad_pkg::ioad_op_t op_q, next_op_q;
    logic [15:0]        addr_q, next_addr_q;
    logic [15:0]        wbuf, next_wbuf;
    logic [15:0]        rbuf, next_rbuf;
    logic [7:0]         wdata_q, next_wdata_q;
    logic               hi_byte, next_hi_byte;
    logic [1:0]         t3_cnt, next_t3_cnt;
    logic               mrd, mwr, ird, iwr;
    logic               next_mrd, next_mwr, next_ird, next_iwr;
    logic               next_busy, next_done;
    logic               is_read;

    // read-type ops capture the bus at the end of T3
    assign is_read = (op_q == ioad_pkg::IOAD_MEM_READ) ||
                     (op_q == ioad_pkg::IOAD_PORT_IN) ||
                     (op_q == ioad_pkg::IOAD_PAIR_READ);

    // next-state and datapath
    always_comb begin
        next_state   = state;
        next_op_q    = op_q;
        next_addr_q  = addr_q;
        next_wbuf    = wbuf;
        next_rbuf    = rbuf;
        next_wdata_q = wdata_q;
        next_hi_byte = hi_byte;
        next_t3_cnt  = t3_cnt;
        next_mrd     = 1'b0;
        next_mwr     = 1'b0;
        next_ird     = 1'b0;
        next_iwr     = 1'b0;
        next_done    = 1'b0;
        case (state)
            ST_IDLE: begin
                if (req) begin
                    next_state   = ST_T1;
                    next_op_q    = op;
                    next_wbuf    = write_data;
                    next_hi_byte = 1'b0;
                    next_rbuf    = 16'h0000;
                    if (op == ioad_pkg::IOAD_PORT_IN ||
                        op == ioad_pkg::IOAD_PORT_OUT) begin
                        next_addr_q = {byte2, byte2};       // [R3]
                    end else begin
                        next_addr_q = {byte3, byte2};       // [R4] [R8]
                    end
                    next_wdata_q = write_data[7:0];         // [R7]
                end
            end
            ST_T1: next_state = ST_T2;
            ST_T2: begin
                next_state  = ST_T3;
                next_t3_cnt = 2'(ioad_pkg::STROBE_CYCLES - 1);
                case (op_q)
                    ioad_pkg::IOAD_PORT_IN:  next_ird = 1'b1;
                    ioad_pkg::IOAD_PORT_OUT: next_iwr = 1'b1;
                    ioad_pkg::IOAD_MEM_WRITE,
                    ioad_pkg::IOAD_PAIR_WRITE: next_mwr = 1'b1; // [R5]
                    default: next_mrd = 1'b1;
                endcase
            end
            ST_T3: begin
                next_mrd = mrd;
                next_mwr = mwr;
                next_ird = ird;
                next_iwr = iwr;
                if (t3_cnt != 2'd0) begin
                    next_t3_cnt = t3_cnt - 2'd1;
                end else begin
                    next_mrd   = 1'b0;
                    next_mwr   = 1'b0;
                    next_ird   = 1'b0;
                    next_iwr   = 1'b0;
                    next_state = ST_GAP;
                    // low byte first, high byte at the next address
                    if (is_read && hi_byte) begin
                        next_rbuf[15:8] = bus.rdata;        // [R7]
                    end else if (is_read) begin
                        next_rbuf[7:0] = bus.rdata;
                    end
                end
            end
            ST_GAP: begin
                if ((op_q == ioad_pkg::IOAD_PAIR_READ ||
                     op_q == ioad_pkg::IOAD_PAIR_WRITE) && !hi_byte) begin
                    next_state   = ST_T1;
                    next_hi_byte = 1'b1;
                    next_addr_q  = addr_q + 16'h0001;       // [R5] [R8]
                    next_wdata_q = wbuf[15:8];
                end else begin
                    next_state = ST_IDLE;
                    next_done  = 1'b1;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        next_busy = (next_state != ST_IDLE);
    end

    // registers only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state   <= ST_IDLE;
            op_q    <= ioad_pkg::IOAD_MEM_READ;
            addr_q  <= 16'h0000;
            wbuf    <= 16'h0000;
            rbuf    <= 16'h0000;
            wdata_q <= ioad_pkg::RESET_BYTE;
            hi_byte <= 1'b0;
            t3_cnt  <= 2'd0;
            mrd     <= 1'b0;
            mwr     <= 1'b0;
            ird     <= 1'b0;
            iwr     <= 1'b0;
            busy    <= 1'b0;
            done    <= 1'b0;
        end else begin
            state   <= next_state;
            op_q    <= next_op_q;
            addr_q  <= next_addr_q;
            wbuf    <= next_wbuf;
            rbuf    <= next_rbuf;
            wdata_q <= next_wdata_q;
            hi_byte <= next_hi_byte;
            t3_cnt  <= next_t3_cnt;
            mrd     <= next_mrd;
            mwr     <= next_mwr;
            ird     <= next_ird;
            iwr     <= next_iwr;
            busy    <= next_busy;
            done    <= next_done;
        end
    end

    // bus and answer come straight from flops
    assign bus.addr                = addr_q;
    assign bus.wdata               = wdata_q;
    assign bus.memory_read_strobe  = mrd;
    assign bus.memory_write_strobe = mwr;
    assign bus.io_read_strobe      = ird;
    assign bus.io_write_strobe     = iwr;
    assign read_data               = rbuf;
endmodule : ioad_cpu_end

`default_nettype wire

// ==== design/ioad_decoder.sv ====
// Purpose : port address decoder; device enables and qualified strobes
// Assumes : strobes and address come from logic on the same clock
// Notes   : every output lags the bus by one clock
//
// Contract
// (R1) exclusive mode decodes address to one enable
// (R2) linear mode: one address bit per device
// (R3) isolated linear: port byte gives six enables
// (R4) mapped linear: address gives thirteen enables
// (R5) any memory access reaches a mapped port
// (R6) byte space with unique 16-bit addresses
// (R7) bit 0 least, bit 7 most significant
// (R8) instruction bytes successive, first byte addresses
// (R9) mapped mode: high address bit flags I/O
// (R10) memory and I/O differ only by strobes
// (R11) enable only under matching strobe and address
// (R12) software sets exactly one linear enable bit
`default_nettype none

module ioad_decoder #(
    parameter int NUM_DEV = ioad_pkg::MM_DEVS
) (
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    // configuration straps, same clock
    input  wire ioad_pkg::ioad_map_t           map_mode,
    input  wire ioad_pkg::ioad_sel_t           select_mode,
    // peripheral side
    output logic [NUM_DEV-1:0]                 device_enable,
    output logic [ioad_pkg::PORT_SEL_W-1:0]    port_select,
    output logic                               port_read_strobe,
    output logic                               port_write_strobe,
    output logic [ioad_pkg::DATA_W-1:0]        port_write_data,
    input  wire logic [ioad_pkg::DATA_W-1:0]   port_read_data,
    // memory side
    output logic                               memory_select,
    output logic                               memory_read,
    output logic                               memory_write,
    output logic [ioad_pkg::ADDR_W-1:0]        memory_address,
    input  wire logic [ioad_pkg::DATA_W-1:0]   memory_read_data,
    // status
    output logic                               select_conflict,
    output logic                               decode_miss,
    // processor bus
    ioad_bus_if.dec                            bus
);
    // =========================================================
    // cycle classification
    logic                        any_mem, any_io, io_flag;
    logic                        io_cycle, mem_cycle, rd_cycle, wr_cycle;

    // isolated: memory and I/O differ only by strobes; mapped: the high address bit tells them apart
    always_comb begin
        any_mem   = bus.memory_read_strobe | bus.memory_write_strobe;
        any_io    = bus.io_read_strobe | bus.io_write_strobe;
        io_flag   = bus.addr[ioad_pkg::IO_FLAG_BIT];
        if (map_mode == ioad_pkg::IOAD_MAPPED) begin
            io_cycle  = any_mem & io_flag;                // [R9] [R5]
            mem_cycle = any_mem & ~io_flag;               // [R9]
            rd_cycle  = bus.memory_read_strobe;
            wr_cycle  = bus.memory_write_strobe;
        end else begin
            io_cycle  = any_io;                           // [R10]
            mem_cycle = any_mem;                          // [R6] [R10]
            rd_cycle  = bus.io_read_strobe | bus.memory_read_strobe;
            wr_cycle  = bus.io_write_strobe | bus.memory_write_strobe;
        end
    end

    // =========================================================
    // enable field extraction
    logic [ioad_pkg::MM_FIELD_W-1:0] field;
    logic [NUM_DEV-1:0]              raw_linear, raw_excl;
    logic                            linear_ok;
    logic [ioad_pkg::MM_FIELD_W-1:0] dev_index;

    // isolated space uses only the port byte, bit 0 = lowest
    always_comb begin
        field = '0;
        if (map_mode == ioad_pkg::IOAD_MAPPED) begin
            field = bus.addr[ioad_pkg::ENABLE_LSB +:
                             ioad_pkg::MM_FIELD_W];      // [R4] [R7]
        end else begin
            field[ioad_pkg::ISO_FIELD_W-1:0] =
                bus.addr[ioad_pkg::ENABLE_LSB +:
                         ioad_pkg::ISO_FIELD_W];         // [R3] [R7]
        end
        dev_index = field;
    end

    // linear: each bit enables its own device, nothing decoded
    always_comb begin
        raw_linear = '0;
        for (int i = 0; i < NUM_DEV; i++) begin
            if (i < ioad_pkg::MM_FIELD_W) begin
                raw_linear[i] = field[i];                 // [R2]
            end
        end
        // two bits at once would put two devices on the data bus
        linear_ok = $onehot(raw_linear);                  // [R12]
    end

    // exclusive: the field is a binary device number
    always_comb begin
        raw_excl = '0;
        for (int i = 0; i < NUM_DEV; i++) begin
            if (dev_index == ioad_pkg::MM_FIELD_W'(i)) begin
                raw_excl[i] = 1'b1;                       // [R1]
            end
        end
    end

    // =========================================================
    // registered outputs
    logic [NUM_DEV-1:0]               next_enable;
    logic [ioad_pkg::PORT_SEL_W-1:0]  next_port_select;
    logic                             next_prd, next_pwr;
    logic [ioad_pkg::DATA_W-1:0]      next_pwdata;
    logic                             next_msel, next_mrd, next_mwr;
    logic [ioad_pkg::ADDR_W-1:0]      next_maddr;
    logic [ioad_pkg::DATA_W-1:0]      next_rdata, rdata_q;
    logic                             next_conflict, next_miss;

    always_comb begin
        next_enable      = '0;
        next_port_select = bus.addr[ioad_pkg::PORT_SEL_W-1:0];
        next_prd         = 1'b0;
        next_pwr         = 1'b0;
        next_pwdata      = bus.wdata;
        next_msel        = 1'b0;
        next_mrd         = 1'b0;
        next_mwr         = 1'b0;
        next_maddr       = bus.addr;
        next_rdata       = rdata_q;
        next_conflict    = 1'b0;
        next_miss        = 1'b0;
        if (io_cycle) begin
            if (select_mode == ioad_pkg::IOAD_LINEAR) begin
                if (linear_ok) begin
                    next_enable = raw_linear;             // [R2] [R11]
                end else begin
                    next_conflict = |raw_linear;
                    next_miss     = ~|raw_linear;
                end
            end else begin
                next_enable = raw_excl;                   // [R1] [R11]
                next_miss   = ~|raw_excl;
            end
            // strobes only pass when some device is enabled
            next_prd   = rd_cycle & |next_enable;         // [R11]
            next_pwr   = wr_cycle & |next_enable;         // [R11]
            if (rd_cycle) begin
                next_rdata = port_read_data;              // [R5]
            end
        end else if (mem_cycle) begin
            next_msel  = 1'b1;                            // [R10]
            next_mrd   = rd_cycle;
            next_mwr   = wr_cycle;
            if (rd_cycle) begin
                next_rdata = memory_read_data;            // [R6]
            end
        end
    end

    // registers only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            device_enable     <= '0;
            port_select       <= '0;
            port_read_strobe  <= 1'b0;
            port_write_strobe <= 1'b0;
            port_write_data   <= ioad_pkg::RESET_BYTE;
            memory_select     <= 1'b0;
            memory_read       <= 1'b0;
            memory_write      <= 1'b0;
            memory_address    <= '0;
            rdata_q           <= ioad_pkg::RESET_BYTE;
            select_conflict   <= 1'b0;
            decode_miss       <= 1'b0;
        end else begin
            device_enable     <= next_enable;
            port_select       <= next_port_select;
            port_read_strobe  <= next_prd;
            port_write_strobe <= next_pwr;
            port_write_data   <= next_pwdata;
            memory_select     <= next_msel;
            memory_read       <= next_mrd;
            memory_write      <= next_mwr;
            memory_address    <= next_maddr;
            rdata_q           <= next_rdata;
            select_conflict   <= next_conflict;
            decode_miss       <= next_miss;
        end
    end

    // read data held until the next read cycle replaces it
    assign bus.rdata = rdata_q;
endmodule : ioad_decoder

`default_nettype wire

// ==== tb/ioad_chk.sv ====
// Purpose : bus and decoder output checks
// Assumes : one clock, async active-low reset
// Notes   : plain inputs, instanced beside the bus
`default_nettype none

module ioad_chk #(
    parameter int NUM_DEV = 13
) (
    // clock and reset
    input  wire logic               clock,
    input  wire logic               rst_n,
    // processor bus
    input  wire logic [15:0]        addr,
    input  wire logic [7:0]         wdata,
    input  wire logic               memory_read_strobe,
    input  wire logic               memory_write_strobe,
    input  wire logic               io_read_strobe,
    input  wire logic               io_write_strobe,
    // decoder outputs
    input  wire logic [NUM_DEV-1:0] device_enable,
    input  wire logic [1:0]         port_select,
    input  wire logic               port_read_strobe,
    input  wire logic               port_write_strobe,
    input  wire logic [7:0]         port_write_data,
    input  wire logic               memory_read,
    input  wire logic               memory_write,
    input  wire logic [15:0]        memory_address,
    input  wire logic               select_conflict,
    input  wire logic               decode_miss
);
    timeunit 1ns;
    timeprecision 1ns;
    // =========================================================
    // helpers; decoder enables and strobes key off a bus strobe
    logic any_s, any_w;
    assign any_s = memory_read_strobe | memory_write_strobe |
                   io_read_strobe | io_write_strobe;
    assign any_w = memory_write_strobe | io_write_strobe;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // =========================================================
    // assertions
    chk_strobe_two_cycles: assert property (
        $rose(any_s) |-> any_s [*2] ##1 !any_s)
        else $error("strobe length");
    chk_one_strobe: assert property (
        $onehot0({memory_read_strobe, memory_write_strobe,
                  io_read_strobe, io_write_strobe}))
        else $error("two strobes");
    chk_enable_cause: assert property (
        (|device_enable) |-> $past(any_s))
        else $error("enable, no strobe");
    chk_enable_onehot: assert property (
        $onehot0(device_enable))
        else $error("two enables");
    chk_port_select: assert property (
        (port_read_strobe || port_write_strobe) |->
        port_select == $past(addr[1:0]) && (|device_enable))
        else $error("port select");
    chk_write_data: assert property (
        port_write_strobe |->
        port_write_data == $past(wdata) && $past(any_w))
        else $error("write data");
    chk_memory_addr: assert property (
        (memory_read || memory_write) |->
        memory_address == $past(addr) && device_enable == '0)
        else $error("memory cycle");
    chk_conflict_quiet: assert property (
        select_conflict |-> device_enable == '0
        && !port_read_strobe && !port_write_strobe)
        else $error("conflict enabled");
    chk_miss_quiet: assert property (
        decode_miss |-> device_enable == '0)
        else $error("miss enabled");
    chk_addr_hold: assert property (
        any_s && $past(any_s) |-> $stable(addr))
        else $error("address moved");
endmodule // ioad_chk

`default_nettype wire

// ==== tb/test_io_port_address_decoder.sv ====
// Purpose : self-checking bench for the decoder pair
// Assumes : one op at a time
// Notes   : memory data follows its address, so pairs show order
`default_nettype none

module test_io_port_address_decoder;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NDEV = ioad_pkg::MM_DEVS;
    // =========================================================
    // signals
    logic                clock = 1'b0;
    logic                rst_n = 1'b0;
    logic                req = 1'b0;
    ioad_pkg::ioad_op_t  op = ioad_pkg::IOAD_MEM_READ;
    logic [7:0]          byte2 = 8'h00;
    logic [7:0]          byte3 = 8'h00;
    logic [15:0]         write_data = 16'h0000;
    ioad_pkg::ioad_map_t map_mode = ioad_pkg::IOAD_ISOLATED;
    ioad_pkg::ioad_sel_t select_mode = ioad_pkg::IOAD_LINEAR;
    logic [7:0]          port_read_data = 8'h00;
    logic [7:0]          memory_read_data = 8'h00;
    logic                busy, done, port_read_strobe, port_write_strobe;
    logic                memory_select, memory_read, memory_write;
    logic                select_conflict, decode_miss;
    logic [15:0]         read_data, memory_address;
    logic [NDEV-1:0]     device_enable, seen_en;
    logic [1:0]          port_select, seen_ps;
    logic [7:0]          port_write_data, seen_wd;
    logic [15:0]         seen_ma;
    logic                seen_mem, seen_miss, seen_conf;
    int                  num_errors = 0;
    int                  checked = 0;
    int                  cycles = 0;

    always #25 clock = ~clock;
    ioad_bus_if bus ();
    ioad_cpu_end ioad_cpu_end_i (.clock, .rst_n, .req, .op, .byte2, .byte3,
        .write_data, .busy, .done, .read_data, .bus);
    ioad_decoder #(.NUM_DEV(NDEV)) ioad_decoder_i (.clock, .rst_n, .map_mode,
        .select_mode, .device_enable, .port_select, .port_read_strobe,
        .port_write_strobe, .port_write_data, .port_read_data, .memory_select,
        .memory_read, .memory_write, .memory_address, .memory_read_data,
        .select_conflict, .decode_miss, .bus);
    ioad_chk #(.NUM_DEV(NDEV)) ioad_chk_i (.clock, .rst_n, .addr(bus.addr),
        .wdata(bus.wdata), .memory_read_strobe(bus.memory_read_strobe),
        .memory_write_strobe(bus.memory_write_strobe),
        .io_read_strobe(bus.io_read_strobe),
        .io_write_strobe(bus.io_write_strobe), .device_enable, .port_select,
        .port_read_strobe, .port_write_strobe, .port_write_data, .memory_read,
        .memory_write, .memory_address, .select_conflict, .decode_miss);

    // memory answers a pattern of its address, so byte order shows;
    // capture what the peripheral side saw; hang guard far above need
    always @(posedge clock) begin
        memory_read_data <= memory_address[7:0] ^ 8'h5a;
        if (port_read_strobe || port_write_strobe) begin
            seen_en <= device_enable;
            seen_ps <= port_select;
            seen_wd <= port_write_data;
        end
        if (memory_read || memory_write) begin
            seen_mem <= 1'b1;
            seen_ma  <= memory_address;
        end
        if (decode_miss) seen_miss <= 1'b1;
        if (select_conflict) seen_conf <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            tally_and_finish();
        end
    end
    // =========================================================
    // tasks
    task automatic tally_and_finish;
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checked++;
        if (seen !== want) begin
            num_errors++;
            $display("BAD at %0t: seen %h want %h", $time, seen, want);
        end
    endtask
    // one op, then wait for done
    task automatic run(input logic mm, input logic lin,
                       input ioad_pkg::ioad_op_t o, input logic [15:0] a,
                       input logic [15:0] wd, input logic [7:0] prd);
        int n;
        @(posedge clock);
        map_mode <= ioad_pkg::ioad_map_t'(mm);
        select_mode <= ioad_pkg::ioad_sel_t'(lin);
        req <= 1'b1;
        op <= o;
        byte2 <= a[7:0];
        byte3 <= a[15:8];
        write_data <= wd;
        port_read_data <= prd;
        @(posedge clock);
        req <= 1'b0;
        {seen_en, seen_ps, seen_wd, seen_ma, seen_mem, seen_miss,
            seen_conf} <= '0;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (done !== 1'b1 && n < 20);
        if (done !== 1'b1) begin
            num_errors++;
            $display("BAD at %0t: no done", $time);
        end
    endtask
    // isolated linear: each of six devices by its own bit
    task automatic t_iso_linear;
        for (int i = 0; i < ioad_pkg::ISO_DEVS; i++) begin
            run(0, 1, ioad_pkg::IOAD_PORT_IN,
                16'((1 << (2 + i)) | (i % 3)), '0, 8'h80 | 8'(i));
            check(16'(seen_en), 16'(1 << i));
            check(16'(seen_ps), 16'(i % 3));
            check(read_data, {8'h00, 8'h80 | 8'(i)});
        end
    endtask
    // isolated exclusive; index past the end misses
    task automatic t_iso_excl;
        for (int k = 0; k <= NDEV; k++) begin
            run(0, 0, ioad_pkg::IOAD_PORT_OUT, 16'((k << 2) | 1),
                16'(8'hc0 | 8'(k)), 8'h00);
            check(16'(seen_en), k < NDEV ? 16'(1 << k) : 16'h0000);
            check(16'(seen_miss), 16'(k >= NDEV));
            if (k < NDEV) check(16'(seen_wd), 16'(8'hc0 | 8'(k)));
        end
    endtask
    // mapped linear: thirteen devices, high bit flags I/O
    task automatic t_map_linear;
        for (int i = 0; i < NDEV; i++) begin
            run(1, 1, ioad_pkg::IOAD_MEM_WRITE,
                16'h8000 | 16'(1 << (2 + i)), 16'(8'h40 | 8'(i)), 8'h00);
            check(16'(seen_en), 16'(1 << i));
            check(16'(seen_wd), 16'(8'h40 | 8'(i)));
            check(16'(seen_mem), 16'h0000);
        end
        run(1, 1, ioad_pkg::IOAD_MEM_READ, 16'h8010, '0, 8'h77);
        check(read_data, 16'h0077);
        run(1, 1, ioad_pkg::IOAD_PAIR_WRITE, 16'h8020, 16'hbeef, '0);
        check(16'(seen_en), 16'h0008);
        check(16'(seen_wd), 16'h00be);
    endtask
    // mapped memory pair across a page; io strobes ignored
    task automatic t_map_memory;
        run(1, 1, ioad_pkg::IOAD_PAIR_READ, 16'h12ff, '0, '0);
        check(read_data, 16'h5aa5);
        check(seen_ma, 16'h1300);
        check(16'(seen_en), 16'h0000);
        run(1, 1, ioad_pkg::IOAD_PORT_IN, 16'h0004, '0, 8'h11);
        check(16'({seen_en, seen_mem}), 16'h0000);
    endtask
    // two linear bits flagged; isolated memory ignores the high bit
    task automatic t_conflict;
        run(0, 1, ioad_pkg::IOAD_PORT_IN, 16'h000c, '0, 8'h22);
        check(16'(seen_conf), 16'h0001);
        check(16'(seen_en), 16'h0000);
        run(0, 0, ioad_pkg::IOAD_MEM_READ, 16'hc001, '0, '0);
        check(16'({seen_en, seen_mem}), 16'h0001);
        check(read_data, 16'h005b);
    endtask
    // =========================================================
    // main sequence
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        t_iso_linear();
        t_iso_excl();
        t_map_linear();
        t_map_memory();
        t_conflict();
        tally_and_finish();
    end
endmodule // test_io_port_address_decoder

`default_nettype wire
